// ---- rtl/twu_defines.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef TWU_DEFINES_SVH
`define TWU_DEFINES_SVH
`define TWU_OFS_CR 8'h00
`define TWU_OFS_MMR 8'h04
`define TWU_OFS_SMR 8'h08
`define TWU_OFS_INTERNAL_ADDR_VALUE 8'h0C
`define TWU_OFS_CWGR 8'h10
`define TWU_OFS_SR 8'h20
`define TWU_OFS_IER 8'h24
`define TWU_OFS_IDR 8'h28
`define TWU_OFS_IMR 8'h2C
`define TWU_OFS_RHR 8'h30
`define TWU_OFS_THR 8'h34
`define TWU_CR_START 0
`define TWU_CR_STOP 1
`define TWU_CR_MASTER_ENABLE_CMD 2
`define TWU_CR_MASTER_DISABLE_CMD 3
`define TWU_CR_SLAVE_ENABLE_CMD 4
`define TWU_CR_SLAVE_DISABLE_CMD 5
`define TWU_CR_SOFT_RESET_CMD 7
`define TWU_MMR_IASZ_LO 8
`define TWU_MMR_MASTER_DIRECTION 12
`define TWU_MMR_TARGET_DEVICE_ADDRESS_LO 16
`define TWU_SMR_OWN_SLAVE_ADDRESS_LO 16
`define TWU_CWGR_CH_LO 8
`define TWU_CWGR_CK_LO 16
`define TWU_SR_RESET 32'h0000F009
`define TWU_SR_TRANSFER_COMPLETE_FLAG 0
`define TWU_SR_RECEIVE_READY_FLAG 1
`define TWU_SR_TRANSMIT_READY_FLAG 2
`define TWU_SR_SLAVE_DIRECTION_FLAG 3
`define TWU_SR_SLAVE_ACCESS_FLAG 4
`define TWU_SR_GENERAL_CALL_FLAG 5
`define TWU_SR_NACK 8
`define TWU_SR_CLOCK_WAIT_FLAG 10
`define TWU_SR_EOSACC 11
`define TWU_SCL_EXTRA 4
`define TWU_GCALL_ADDR 7'h00
`endif

// ---- rtl/twu_pkg.sv ----
// Types shared by the two-wire unit
package twu_pkg;
  typedef enum logic [2:0] {
    TWU_IDLE,
    TWU_ADDR,
    TWU_SL_RX,
    TWU_SL_TX,
    TWU_M_ADDR,
    TWU_M_DATA,
    TWU_M_STOP
  } twu_state_t;
endpackage

// ---- rtl/twu_two_wire_unit.sv ----
// Two-wire bus controller: register bank, slave engine, master engine
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "twu_defines.svh"
module twu_two_wire_unit (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  // Pin synchronisers, three stages
  logic [2:0] scl_sync_ff, sda_sync_ff;
  logic scl_ff, sda_ff, scl_prev_ff, sda_prev_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      if (scl_sync_ff[1] == scl_sync_ff[2]) scl_ff <= scl_sync_ff[2];
      if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
      scl_prev_ff <= scl_ff;
      sda_prev_ff <= sda_ff;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_ff & scl_prev_ff;
  assign bus_start = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  assign bus_stop = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;

  // Bus access decode; one wait cycle per access
  logic acc_ff, srst_ff;
  logic wr_en, rd_en;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc_ff;
  // Writes land at the edge where waitrequest is seen low
  assign wr_en = avs_write_i & acc_ff;
  assign rd_en = avs_read_i & ~acc_ff;
  logic cr_wr, mmr_wr, smr_wr, internal_addr_value_wr, cwgr_wr, ier_wr, idr_wr, thr_wr, rhr_rd, sr_rd;
  assign cr_wr = wr_en && avs_address_i == `TWU_OFS_CR;
  assign mmr_wr = wr_en && avs_address_i == `TWU_OFS_MMR;
  assign smr_wr = wr_en && avs_address_i == `TWU_OFS_SMR;
  assign internal_addr_value_wr = wr_en && avs_address_i == `TWU_OFS_INTERNAL_ADDR_VALUE;
  assign cwgr_wr = wr_en && avs_address_i == `TWU_OFS_CWGR;
  assign ier_wr = wr_en && avs_address_i == `TWU_OFS_IER;
  assign idr_wr = wr_en && avs_address_i == `TWU_OFS_IDR;
  assign thr_wr = wr_en && avs_address_i == `TWU_OFS_THR;
  assign rhr_rd = rd_en && avs_address_i == `TWU_OFS_RHR;
  assign sr_rd = rd_en && avs_address_i == `TWU_OFS_SR;
  logic [31:0] wd;
  assign wd = avs_writedata_i;

  // Access phase toggle; soft reset pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) acc_ff <= 1'b0;
    else acc_ff <= (avs_read_i | avs_write_i) & ~acc_ff;
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) srst_ff <= 1'b0;
    else srst_ff <= cr_wr & wd[`TWU_CR_SOFT_RESET_CMD];
  end

  // Configuration registers
  logic [6:0] target_device_address_ff, own_slave_address_ff;
  logic master_direction_ff;
  logic [1:0] iasz_ff;
  logic [23:0] internal_addr_value_ff;
  logic [7:0] low_divider_ff, high_divider_ff;
  logic [2:0] clock_divider_exp_ff;
  logic [15:0] imr_ff;
  logic master_enable_cmd_ff, slave_enable_cmd_ff, general_call_flag_ff, gcall_win_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_device_address_ff <= 7'h00;
      master_direction_ff <= 1'b0;
      iasz_ff <= 2'h0;
      internal_addr_value_ff <= 24'h000000;
      low_divider_ff <= 8'h00;
      high_divider_ff <= 8'h00;
      clock_divider_exp_ff <= 3'h0;
      imr_ff <= 16'h0000;
    end else if (srst_ff) begin
      target_device_address_ff <= 7'h00;
      master_direction_ff <= 1'b0;
      iasz_ff <= 2'h0;
      internal_addr_value_ff <= 24'h000000;
      low_divider_ff <= 8'h00;
      high_divider_ff <= 8'h00;
      clock_divider_exp_ff <= 3'h0;
      imr_ff <= 16'h0000;
    end else begin
      if (mmr_wr) begin
        target_device_address_ff <= wd[`TWU_MMR_TARGET_DEVICE_ADDRESS_LO +: 7];
        master_direction_ff <= wd[`TWU_MMR_MASTER_DIRECTION];
        iasz_ff <= wd[`TWU_MMR_IASZ_LO +: 2];
      end
      if (internal_addr_value_wr) internal_addr_value_ff <= wd[23:0];
      if (cwgr_wr) begin
        low_divider_ff <= wd[7:0];
        high_divider_ff <= wd[`TWU_CWGR_CH_LO +: 8];
        clock_divider_exp_ff <= wd[`TWU_CWGR_CK_LO +: 3];
      end
      if (ier_wr) imr_ff <= imr_ff | wd[15:0];
      else if (idr_wr) imr_ff <= imr_ff & ~wd[15:0];
    end
  end
  // own address writable before enable or after general call
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) own_slave_address_ff <= 7'h00;
    else if (srst_ff) own_slave_address_ff <= 7'h00;
    else if (smr_wr && (!slave_enable_cmd_ff || gcall_win_ff)) own_slave_address_ff <= wd[`TWU_SMR_OWN_SLAVE_ADDRESS_LO +: 7];
  end

  // Engine state
  twu_pkg::twu_state_t st_ff;
  logic [7:0] shr_ff, rhr_ff, thr_ff;
  logic [3:0] bit_ff;
  logic thr_full_ff, receive_ready_flag_ff, transmit_ready_flag_ff, transfer_complete_flag_ff, slave_access_flag_ff, slave_direction_flag_ff;
  logic nack_ff, eosacc_ff, clock_wait_flag_ff, master_disable_cmd_pend_ff, slave_disable_cmd_pend_ff, stop_req_ff, start_req_ff;
  logic rx_pend_ff, sda_drv_ff, scl_drv_ff;
  logic [1:0] ia_cnt_ff;
  logic [17:0] div_ff;
  logic [17:0] phase_len;
  assign phase_len = ((scl_ff ? {10'h000, high_divider_ff} : {10'h000, low_divider_ff}) << clock_divider_exp_ff)
                     + 18'(`TWU_SCL_EXTRA);
  logic stretch;
  // stretch while data missing or registers full
  assign stretch = (st_ff == twu_pkg::TWU_SL_TX && !thr_full_ff && bit_ff == 4'h0) ||
                   (st_ff == twu_pkg::TWU_SL_RX && rx_pend_ff && receive_ready_flag_ff);

  // Register read mux
  logic [31:0] sr_val;
  assign sr_val = {16'h0000, 4'hF, eosacc_ff, clock_wait_flag_ff, 1'b0, nack_ff, 2'b00, general_call_flag_ff,
                   slave_access_flag_ff, slave_direction_flag_ff, transmit_ready_flag_ff, receive_ready_flag_ff, transfer_complete_flag_ff};
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) avs_readdata_o <= 32'h00000000;
    else if (rd_en) begin
      // reserved and write-only offsets read zero
      case (avs_address_i)
        `TWU_OFS_MMR: avs_readdata_o <= {9'h000, target_device_address_ff, 3'h0, master_direction_ff, 2'h0, iasz_ff, 8'h00};
        `TWU_OFS_SMR: avs_readdata_o <= {9'h000, own_slave_address_ff, 16'h0000};
        `TWU_OFS_INTERNAL_ADDR_VALUE: avs_readdata_o <= {8'h00, internal_addr_value_ff};
        `TWU_OFS_CWGR: avs_readdata_o <= {13'h0000, clock_divider_exp_ff, high_divider_ff, low_divider_ff};
        `TWU_OFS_SR: avs_readdata_o <= sr_val;
        `TWU_OFS_IMR: avs_readdata_o <= {16'h0000, imr_ff};
        `TWU_OFS_RHR: avs_readdata_o <= {24'h000000, rhr_ff};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Main engine
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i || srst_ff) begin
      st_ff <= twu_pkg::TWU_IDLE;
      shr_ff <= 8'h00;
      rhr_ff <= 8'h00;
      thr_ff <= 8'h00;
      bit_ff <= 4'h0;
      thr_full_ff <= 1'b0;
      receive_ready_flag_ff <= 1'b0;
      transmit_ready_flag_ff <= 1'b0;
      transfer_complete_flag_ff <= 1'b1;
      gcall_win_ff <= 1'b0;
      slave_access_flag_ff <= 1'b0;
      slave_direction_flag_ff <= 1'b1;
      nack_ff <= 1'b0;
      eosacc_ff <= 1'b0;
      clock_wait_flag_ff <= 1'b0;
      general_call_flag_ff <= 1'b0;
      master_enable_cmd_ff <= 1'b0;
      slave_enable_cmd_ff <= 1'b0;
      master_disable_cmd_pend_ff <= 1'b0;
      slave_disable_cmd_pend_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      start_req_ff <= 1'b0;
      rx_pend_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      scl_drv_ff <= 1'b0;
      ia_cnt_ff <= 2'h0;
      div_ff <= 18'h00000;
    end else begin
      // Commands; enable only without matching disable
      if (cr_wr) begin
        if (wd[`TWU_CR_MASTER_ENABLE_CMD] && !wd[`TWU_CR_MASTER_DISABLE_CMD]) begin
          master_enable_cmd_ff <= 1'b1;
          transmit_ready_flag_ff <= 1'b1;
        end
        if (wd[`TWU_CR_MASTER_DISABLE_CMD]) master_disable_cmd_pend_ff <= 1'b1;
        if (wd[`TWU_CR_SLAVE_ENABLE_CMD] && !wd[`TWU_CR_SLAVE_DISABLE_CMD]) slave_enable_cmd_ff <= 1'b1;
        if (wd[`TWU_CR_SLAVE_DISABLE_CMD]) slave_disable_cmd_pend_ff <= 1'b1;
        if (wd[`TWU_CR_START]) start_req_ff <= 1'b1;
        if (wd[`TWU_CR_STOP]) stop_req_ff <= 1'b1;
      end
      if (master_disable_cmd_pend_ff && st_ff == twu_pkg::TWU_IDLE && !thr_full_ff) begin
        master_enable_cmd_ff <= 1'b0;
        master_disable_cmd_pend_ff <= 1'b0;
      end
      if (slave_disable_cmd_pend_ff && (st_ff == twu_pkg::TWU_IDLE || bit_ff == 4'h0) && !thr_full_ff) begin
        slave_enable_cmd_ff <= 1'b0;
        slave_disable_cmd_pend_ff <= 1'b0;
      end
      if (sr_rd) begin
        nack_ff <= 1'b0;
        eosacc_ff <= 1'b0;
        general_call_flag_ff <= 1'b0;
      end
      // Address window after a general call survives the status read
      if (smr_wr || bus_stop) gcall_win_ff <= 1'b0;
      if (thr_wr) begin
        thr_ff <= wd[7:0];
        thr_full_ff <= 1'b1;
        transmit_ready_flag_ff <= 1'b0;
        if (master_enable_cmd_ff && !master_direction_ff) start_req_ff <= 1'b1;
      end
      if (rhr_rd) receive_ready_flag_ff <= 1'b0;
      clock_wait_flag_ff <= stretch;
      scl_drv_ff <= stretch;
      if (rx_pend_ff && !(receive_ready_flag_ff && !rhr_rd)) begin
        rhr_ff <= shr_ff;
        receive_ready_flag_ff <= 1'b1;
        rx_pend_ff <= 1'b0;
      end
      if (bus_stop || bus_start) begin
        // end of access at stop or restart
        rx_pend_ff <= 1'b0;
        if (slave_access_flag_ff) eosacc_ff <= 1'b1;
        slave_access_flag_ff <= 1'b0;
        sda_drv_ff <= 1'b0;
        bit_ff <= 4'h0;
        if (bus_stop) transfer_complete_flag_ff <= 1'b1;
        if (bus_start && slave_enable_cmd_ff) begin
          st_ff <= twu_pkg::TWU_ADDR;
        end else if (!master_enable_cmd_ff) st_ff <= twu_pkg::TWU_IDLE;
      end else begin
        case (st_ff)
          twu_pkg::TWU_IDLE: begin
            // master frame start with target address
            if (master_enable_cmd_ff && start_req_ff) begin
              start_req_ff <= 1'b0;
              transfer_complete_flag_ff <= 1'b0;
              shr_ff <= {target_device_address_ff, master_direction_ff && iasz_ff == 2'h0};
              ia_cnt_ff <= iasz_ff;
              sda_drv_ff <= 1'b1;
              bit_ff <= 4'h0;
              div_ff <= 18'h00000;
              st_ff <= twu_pkg::TWU_M_ADDR;
            end
          end
          twu_pkg::TWU_ADDR: if (scl_rise) begin
            shr_ff <= {shr_ff[6:0], sda_ff};
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              if (shr_ff[6:0] == own_slave_address_ff) begin
                slave_access_flag_ff <= 1'b1;
                slave_direction_flag_ff <= sda_ff;
                transfer_complete_flag_ff <= 1'b0;
                bit_ff <= 4'h8;
              end else if (shr_ff[6:0] == `TWU_GCALL_ADDR && !sda_ff) begin
                general_call_flag_ff <= 1'b1;
                gcall_win_ff <= 1'b1;
                slave_access_flag_ff <= 1'b1;
                slave_direction_flag_ff <= 1'b0;
                bit_ff <= 4'h8;
              end else begin
                transfer_complete_flag_ff <= 1'b1;
                st_ff <= twu_pkg::TWU_IDLE;
              end
            end
          end else if (scl_fall && bit_ff == 4'h8) begin
            sda_drv_ff <= 1'b1;
          end else if (scl_fall && bit_ff == 4'h9) begin
            sda_drv_ff <= 1'b0;
            bit_ff <= 4'h0;
            st_ff <= slave_direction_flag_ff ? twu_pkg::TWU_SL_TX : twu_pkg::TWU_SL_RX;
          end else if (scl_rise && bit_ff == 4'h8) bit_ff <= 4'h9;
          twu_pkg::TWU_SL_RX: begin
            if (scl_rise && bit_ff < 4'h8) begin
              shr_ff <= {shr_ff[6:0], sda_ff};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              rx_pend_ff <= 1'b1;
              sda_drv_ff <= 1'b1;
              bit_ff <= 4'h9;
            end else if (scl_fall && bit_ff == 4'h9) begin
              sda_drv_ff <= 1'b0;
              bit_ff <= 4'h0;
            end
          end
          twu_pkg::TWU_SL_TX: begin
            if (bit_ff == 4'h0 && thr_full_ff && !scl_ff) begin
              shr_ff <= thr_ff;
              thr_full_ff <= 1'b0;
              sda_drv_ff <= ~thr_ff[7];
              bit_ff <= 4'h1;
            end else if (scl_fall && bit_ff != 4'h0 && bit_ff < 4'h8) begin
              shr_ff <= {shr_ff[6:0], 1'b0};
              sda_drv_ff <= ~shr_ff[6];
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              sda_drv_ff <= 1'b0;
              bit_ff <= 4'h9;
            end else if (scl_rise && bit_ff == 4'h9) begin
              transmit_ready_flag_ff <= 1'b1;
              bit_ff <= 4'hA;
              // Master refused the byte: stop sending, never stretch
              if (sda_ff) begin
                nack_ff <= 1'b1;
                st_ff <= twu_pkg::TWU_IDLE;
              end
            end else if (scl_fall && bit_ff == 4'hA) bit_ff <= 4'h0;
          end
          default: begin
            // Master engine: bit timer from divider
            if (div_ff >= phase_len) begin
              div_ff <= 18'h00000;
            end else div_ff <= div_ff + 18'h00001;
          end
        endcase
      end
    end
  end
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_drv_ff;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drv_ff;
endmodule

// ---- tb/twu_bus_master_model.sv ----
// Behavioural two-wire bus master facing the unit
`timescale 1ns/1ps
module twu_bus_master_model #(
  parameter int HALF = 10
) (
  // Clock
  input wire logic sys_clk_i,
  // Line levels and pull-downs
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge sys_clk_i);
  endtask
  // Release the clock, waiting out any stretch by the slave
  task automatic clk_high();
    scl_pull_o <= 1'b0;
    @(posedge sys_clk_i);
    while (scl_i !== 1'b1) @(posedge sys_clk_i);
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    @(posedge sys_clk_i);
    sda_pull_o <= !b;
    half();
    clk_high();
    @(negedge sys_clk_i);
    r = sda_i;
    @(posedge sys_clk_i);
    scl_pull_o <= 1'b1;
  endtask
  task automatic start();
    @(posedge sys_clk_i);
    sda_pull_o <= 1'b0;
    half();
    clk_high();
    sda_pull_o <= 1'b1;
    half();
    scl_pull_o <= 1'b1;
  endtask
  task automatic stop();
    @(posedge sys_clk_i);
    sda_pull_o <= 1'b1;
    half();
    clk_high();
    sda_pull_o <= 1'b0;
    half();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
      output logic ar);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a, ar);
  endtask
endmodule

// ---- tb/twu_checker_sva.sv ----
// Port-level checker for the two-wire unit, bound to its top module
`timescale 1ns/1ps
`include "twu_defines.svh"
module twu_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  logic [4:0] since_sw_ff;
  logic sw_hit;
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  assign sw_hit = !avs_waitrequest_o && ((avs_read_i && avs_address_i == `TWU_OFS_RHR)
    || (avs_write_i && (avs_address_i == `TWU_OFS_THR || avs_address_i == `TWU_OFS_CR)));
  // Cycles since software last read RHR or wrote THR or CR
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_sw_ff <= 5'h1F;
    end else if (sw_hit) begin
      since_sw_ff <= 5'h00;
    end else if (since_sw_ff != 5'h1F) begin
      since_sw_ff <= since_sw_ff + 5'h01;
    end
  end
  sequence req_start;
    $rose(avs_read_i) || $rose(avs_write_i);
  endsequence
  sequence rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  first_wait_a: assert property (req_start |-> avs_waitrequest_o)
    else $error("waitrequest low in first request cycle");
  one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest held past one cycle");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  reserved_zero_a: assert property (
    rd_done ##0 (avs_address_i >= 8'h38) |-> avs_readdata_o == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  stretch_flag_a: assert property (
    rd_done ##0 (avs_address_i == `TWU_OFS_SR && avs_readdata_o[`TWU_SR_CLOCK_WAIT_FLAG])
    |-> (scl_oe_o || $past(scl_oe_o) || $past(scl_oe_o, 2)))
    else $error("clock wait flag without stretching");
  stretch_onset_a: assert property ($rose(scl_oe_o) |-> !scl_i)
    else $error("clock pulled low while high");
  stretch_release_a: assert property ($fell(scl_oe_o) |-> since_sw_ff < 5'h10 || $past(sw_hit))
    else $error("stretch released without software service");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
endmodule
bind twu_two_wire_unit twu_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// ---- tb/twu_two_wire_unit_bench.sv ----
// Self-checking bench for the two-wire unit
`timescale 1ns/1ps
`include "twu_defines.svh"
module twu_two_wire_unit_bench;
  logic sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl, m_sda, scl_line, sda_line, ack;
  logic [7:0] q;
  int n_mismatch;
  int comparisons;
  logic [7:0] zero_ofs [6] = '{`TWU_OFS_MMR, `TWU_OFS_SMR, `TWU_OFS_INTERNAL_ADDR_VALUE, `TWU_OFS_CWGR,
    `TWU_OFS_IMR, `TWU_OFS_RHR};
  // Wired-AND lines with pull-ups
  assign scl_line = !(scl_oe_o || m_scl);
  assign sda_line = !(sda_oe_o || m_sda);
  twu_two_wire_unit dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  twu_bus_master_model m (.sys_clk_i(sys_clk_i), .scl_i(scl_line), .sda_i(sda_line),
    .scl_pull_o(m_scl), .sda_pull_o(m_sda));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
    cmp({31'h0, avs_waitrequest_o}, 32'h0, 32'h1);
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(r, exp, mask);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    int i;
    i = 0;
    do begin
      bus(1'b0, a, 32'h0);
      i++;
    end while ((r & mask) !== (exp & mask) && i < 400);
    cmp(r, exp, mask);
  endtask
  task automatic check_reset();
    rd_cmp(`TWU_OFS_SR, '1, `TWU_SR_RESET);
    foreach (zero_ofs[i]) rd_cmp(zero_ofs[i], '1, 32'h0);
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    n_mismatch++;
    $display("MISMATCH %0t run did not finish", $time);
    tally_and_finish();
  end
  initial begin
    rst_i = 1'b1;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    check_reset();
    bus(1'b1, 8'h38, '1);
    rd_cmp(8'h38, '1, 32'h0);
    rd_cmp(8'hFC, '1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `TWU_OFS_MMR, 32'h005A_0000 | (i << 8) | ((i & 1) << 12));
      rd_cmp(`TWU_OFS_MMR, '1, 32'h005A_0000 | (i << 8) | ((i & 1) << 12));
    end
    bus(1'b1, `TWU_OFS_SMR, 32'h0055_0000);
    bus(1'b1, `TWU_OFS_CR, 32'h0000_0018);
    bus(1'b1, `TWU_OFS_SMR, 32'h0033_0000);
    rd_cmp(`TWU_OFS_SMR, '1, 32'h0055_0000);
    // Slave write, then three more bytes; the first, left unserviced, makes the second force a stretch
    m.start();
    m.xfer({7'h55, 1'b0}, 1'b1, q, ack);
    cmp({31'h0, ack}, 32'h0, 32'h1);
    m.xfer(8'hA5, 1'b1, q, ack);
    poll(`TWU_OFS_SR, 32'h1B, 32'h12);
    rd_cmp(`TWU_OFS_RHR, 32'hFF, 32'hA5);
    rd_cmp(`TWU_OFS_SR, 32'h2, 32'h0);
    fork
      begin
        m.xfer(8'h3C, 1'b1, q, ack);
        m.xfer(8'hC3, 1'b1, q, ack);
        m.xfer(8'h5A, 1'b1, q, ack);
      end
    join_none
    poll(`TWU_OFS_SR, 32'h400, 32'h400);
    cmp({31'h0, scl_line}, 32'h0, 32'h1);
    rd_cmp(`TWU_OFS_RHR, 32'hFF, 32'h3C);
    poll(`TWU_OFS_SR, 32'h2, 32'h2);
    rd_cmp(`TWU_OFS_RHR, 32'hFF, 32'hC3);
    wait fork;
    rd_cmp(`TWU_OFS_SR, 32'h402, 32'h002);
    rd_cmp(`TWU_OFS_RHR, 32'hFF, 32'h5A);
    m.stop();
    poll(`TWU_OFS_SR, 32'h11, 32'h01);
    // Write then repeated start reversing to read, holding register empty
    m.start();
    m.xfer({7'h55, 1'b0}, 1'b1, q, ack);
    m.xfer(8'h11, 1'b1, q, ack);
    m.start();
    fork
      m.xfer({7'h55, 1'b1}, 1'b1, q, ack);
    join_none
    poll(`TWU_OFS_SR, 32'h400, 32'h400);
    rd_cmp(`TWU_OFS_SR, 32'h1, 32'h0);
    bus(1'b1, `TWU_OFS_THR, 32'h96);
    rd_cmp(`TWU_OFS_SR, 32'h4, 32'h0);
    wait fork;
    m.xfer(8'hFF, 1'b1, q, ack);
    cmp({24'h0, q}, 32'h96, 32'hFF);
    poll(`TWU_OFS_SR, 32'h4, 32'h4);
    m.stop();
    poll(`TWU_OFS_SR, 32'h1, 32'h1);
    rd_cmp(`TWU_OFS_RHR, 32'hFF, 32'h11);
    // General call, then software moves the own address
    m.start();
    m.xfer(8'h00, 1'b1, q, ack);
    poll(`TWU_OFS_SR, 32'h20, 32'h20);
    bus(1'b1, `TWU_OFS_SMR, 32'h0033_0000);
    rd_cmp(`TWU_OFS_SMR, '1, 32'h0033_0000);
    m.stop();
    m.start();
    m.xfer({7'h33, 1'b0}, 1'b1, q, ack);
    cmp({31'h0, ack}, 32'h0, 32'h1);
    m.stop();
    bus(1'b1, `TWU_OFS_CR, 32'h0000_0003);
    bus(1'b1, `TWU_OFS_CR, 32'h0000_0080);
    check_reset();
    tally_and_finish();
  end
endmodule
